/* File: hdl/rvs_channel.sv */
`timescale 1ns/1ps
module rvs_channel (
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	input  wire logic                          tick,
	input  wire logic                          monitor_enable,
	input  wire logic                          reg_on,
	input  wire logic                          in_regulation,
	input  wire logic [1:0]                    cmp,
	input  wire logic [1:0][rvs_pkg::CNT_W-1:0] win,
	output logic [1:0]                         status,
	output logic [1:0]                         evt,
	output logic                               valid
);
	// index 0 is undervoltage, index 1 is overvoltage
	rvs_pkg::rvs_chan_state_type      st_q, st_d;
	logic [rvs_pkg::CNT_W-1:0]        settle_q, settle_d;
	logic [1:0][rvs_pkg::CNT_W-1:0]   cnt_q, cnt_d;
	logic [1:0]                       status_d, evt_d;
	logic                             reg_on_q, masked_q, masked_d, active;

	always_comb begin
		st_d     = st_q;
		settle_d = settle_q;
		masked_d = masked_q;
		// blank detection from turn-on until regulation reached
		if (!reg_on)
			masked_d = 1'b1;
		else if (reg_on && !reg_on_q)
			masked_d = 1'b1;
		else if (in_regulation)
			masked_d = 1'b0;
		case (st_q)
			rvs_pkg::CH_OFF: begin
				settle_d = '0;
				if (monitor_enable)
					st_d = rvs_pkg::CH_SETTLE;
			end
			rvs_pkg::CH_SETTLE: begin
				if (!monitor_enable) begin
					st_d = rvs_pkg::CH_OFF;
				end else if (tick) begin
					if (settle_q == rvs_pkg::SETTLE_TICKS - 1'b1)
						st_d = rvs_pkg::CH_ACTIVE;
					else
						settle_d = settle_q + 1'b1;
				end
			end
			rvs_pkg::CH_ACTIVE: begin
				if (!monitor_enable)
					st_d = rvs_pkg::CH_OFF;
			end
			default: st_d = rvs_pkg::CH_OFF;
		endcase
		active = (st_q == rvs_pkg::CH_ACTIVE) && !masked_q && monitor_enable;
		for (int i = 0; i < 2; i++) begin
			cnt_d[i]    = cnt_q[i];
			status_d[i] = status[i];
			if (!active) begin
				cnt_d[i]    = '0;
				status_d[i] = 1'b0;
			end else if (!cmp[i]) begin
				cnt_d[i]    = '0;
				status_d[i] = 1'b0;
			end else if (!status[i] && tick) begin
				// first tick may be partial, so one extra tick keeps the full window
				if (cnt_q[i] >= win[i])
					status_d[i] = 1'b1;
				else
					cnt_d[i] = cnt_q[i] + 1'b1;
			end
			evt_d[i] = status_d[i] & ~status[i];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q     <= rvs_pkg::CH_OFF;
			settle_q <= '0;
			cnt_q    <= '0;
			status   <= '0;
			evt      <= '0;
			valid    <= 1'b0;
			reg_on_q <= 1'b0;
			masked_q <= 1'b1;
		end else begin
			st_q     <= st_d;
			settle_q <= settle_d;
			cnt_q    <= cnt_d;
			status   <= status_d;
			evt      <= evt_d;
			valid    <= (st_d == rvs_pkg::CH_ACTIVE);
			reg_on_q <= reg_on;
			masked_q <= masked_d;
		end
	end

endmodule // rvs_channel

/* File: hdl/rvs_pkg.sv */
package rvs_pkg;

	// clocking: 20 MHz system clock, 100 kHz low-power tick
	localparam int CLK_KHZ = 20000;
	localparam int LP_KHZ  = 100;
	localparam int LP_DIV  = CLK_KHZ / LP_KHZ;
	localparam int NCH     = 4;
	localparam int CNT_W   = 4;

	// register map (byte addresses)
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_THRESH = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_IRQ    = 8'h0c;
	localparam logic [7:0] ADDR_MASK   = 8'h10;
	localparam logic [7:0] ADDR_UNLOCK = 8'h14;

	// unlock key for secure writes, value arbitrary
	localparam logic [31:0] UNLOCK_KEY = 32'h0000_a5c3;

	// threshold register field positions
	localparam int THR_UV_LSB = 0;
	localparam int THR_OV_LSB = 8;

	// reset values
	localparam logic [3:0] MON_EN_RST = 4'hf;
	localparam logic [1:0] UV_DEBOUNCE_SELECT_RST  = 2'h2;
	localparam logic [1:0] OV_DEBOUNCE_SELECT_RST  = 2'h0;
	localparam logic [1:0] TH_RST     = 2'h0;

	// threshold percentages of nominal voltage
	localparam logic [7:0] UV_PCT0 = 8'd95;
	localparam logic [7:0] UV_PCT1 = 8'd93;
	localparam logic [7:0] UV_PCT2 = 8'd91;
	localparam logic [7:0] UV_PCT3 = 8'd89;
	localparam logic [7:0] OV_PCT0 = 8'd105;
	localparam logic [7:0] OV_PCT1 = 8'd107;
	localparam logic [7:0] OV_PCT2 = 8'd109;
	localparam logic [7:0] OV_PCT3 = 8'd111;

	// debounce and settling times in microseconds
	localparam int UV_DB0_US = 5;
	localparam int UV_DB1_US = 15;
	localparam int UV_DB2_US = 30;
	localparam int UV_DB3_US = 40;
	localparam int OV_DB0_US = 30;
	localparam int OV_DB1_US = 50;
	localparam int OV_DB2_US = 80;
	localparam int OV_DB3_US = 125;
	localparam int SETTLE_MAX_US = 30;

	// least time: round up to whole ticks, at least one
	function automatic logic [CNT_W-1:0] ticks_up(input int us);
		int t;
		t = (us * LP_KHZ + 999) / 1000;
		return CNT_W'((t < 1) ? 1 : t);
	endfunction

	// longest time: round down, at least one
	function automatic logic [CNT_W-1:0] ticks_down(input int us);
		int t;
		t = (us * LP_KHZ) / 1000;
		return CNT_W'((t < 1) ? 1 : t);
	endfunction

	localparam logic [CNT_W-1:0] SETTLE_TICKS = ticks_down(SETTLE_MAX_US);

	typedef struct packed {
		logic       secure_en;
		logic [1:0] ov_debounce_select;
		logic [1:0] uv_debounce_select;
		logic [3:0] channel_monitor_enable;
	} rvs_ctrl_type;

	typedef struct packed {
		logic [3:0] ov;
		logic [3:0] uv;
	} rvs_flags_type;

	typedef enum logic [2:0] {
		CH_OFF    = 3'b001,
		CH_SETTLE = 3'b010,
		CH_ACTIVE = 3'b100
	} rvs_chan_state_type;

endpackage

/* File: hdl/rvs_supervisor.sv */
// Behaviour
// - undervoltage code 00/01/10/11 selects 95/93/91/89 percent of nominal
// - overvoltage code 00/01/10/11 selects 105/107/109/111 percent of nominal
// - undervoltage debounce code selects 5, 15, 30 or 40 us
// - undervoltage debounce field resets to 10, the 30 us window
// - shared overvoltage debounce code selects 30, 50, 80 or 125 us
// - overvoltage debounce field resets to 00, the 30 us window
// - per-channel monitor enable bit, 1 enables, 0 disables monitoring
// - every monitor enable bit comes up as 1
// - with secure enable set, monitor enables change only through a secure write
// - detection masked after regulator turn-on until regulation is reached
// - disabled monitor forces its under and overvoltage status to 0
// - settling and debounce timers run on a 100 kHz tick, registers on the 20 MHz system clock
// - four channels, each with independent under and overvoltage supervision
// - result valid only after settling of at most 30 us after enable
`timescale 1ns/1ps
module rvs_supervisor (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic [31:0]      rdata,
	input  wire logic [3:0]  reg_on,
	input  wire logic [3:0]  in_regulation,
	input  wire logic [3:0]  uv_cmp,
	input  wire logic [3:0]  ov_cmp,
	output logic [3:0]       monitor_enable,
	output logic [3:0][7:0]  uv_threshold_pct,
	output logic [3:0][7:0]  ov_threshold_pct,
	output logic [3:0]       undervoltage_status,
	output logic [3:0]       overvoltage_status,
	output logic             irq
);
	// reset release through two flops
	logic rst_meta_q, rst_n_q;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// 100 kHz tick divider
	logic [7:0] div_q, div_d;
	logic       tick_q, tick_d;

	always_comb begin
		if (div_q == 8'(rvs_pkg::LP_DIV - 1)) begin
			div_d  = '0;
			tick_d = 1'b1;
		end else begin
			div_d  = div_q + 1'b1;
			tick_d = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			div_q  <= div_d;
			tick_q <= tick_d;
		end
	end

	// register file
	rvs_pkg::rvs_ctrl_type  ctrl_q, ctrl_d;
	logic [3:0][1:0]        uv_th_q, uv_th_d, ov_th_q, ov_th_d;
	rvs_pkg::rvs_flags_type irq_st_q, irq_st_d, irq_mask_q, irq_mask_d;
	logic                   unlock_q, unlock_d;
	logic [31:0]            rdata_d;
	logic                   irq_d;
	rvs_pkg::rvs_flags_type evt, live;
	logic [3:0]             valid;
	rvs_pkg::rvs_ctrl_type  wr_ctrl;

	always_comb begin
		wr_ctrl    = rvs_pkg::rvs_ctrl_type'(wdata[$bits(rvs_pkg::rvs_ctrl_type)-1:0]);
		ctrl_d     = ctrl_q;
		uv_th_d    = uv_th_q;
		ov_th_d    = ov_th_q;
		irq_mask_d = irq_mask_q;
		unlock_d   = unlock_q;
		irq_st_d   = irq_st_q;
		rdata_d    = '0;
		if (wr_en) begin
			unlock_d = 1'b0;
			case (addr)
				rvs_pkg::ADDR_CTRL: begin
					ctrl_d.secure_en          = wr_ctrl.secure_en;
					ctrl_d.uv_debounce_select = wr_ctrl.uv_debounce_select;
					ctrl_d.ov_debounce_select = wr_ctrl.ov_debounce_select;
					if (!ctrl_q.secure_en || unlock_q)
						ctrl_d.channel_monitor_enable = wr_ctrl.channel_monitor_enable;
				end
				rvs_pkg::ADDR_THRESH: begin
					for (int c = 0; c < rvs_pkg::NCH; c++) begin
						uv_th_d[c] = wdata[rvs_pkg::THR_UV_LSB + 2*c +: 2];
						ov_th_d[c] = wdata[rvs_pkg::THR_OV_LSB + 2*c +: 2];
					end
				end
				rvs_pkg::ADDR_MASK:   irq_mask_d = rvs_pkg::rvs_flags_type'(wdata[7:0]);
				rvs_pkg::ADDR_UNLOCK: unlock_d = (wdata == rvs_pkg::UNLOCK_KEY);
				default: ;
			endcase
		end
		if (rd_en) begin
			case (addr)
				rvs_pkg::ADDR_CTRL:   rdata_d = 32'(ctrl_q);
				rvs_pkg::ADDR_THRESH: begin
					for (int c = 0; c < rvs_pkg::NCH; c++) begin
						rdata_d[rvs_pkg::THR_UV_LSB + 2*c +: 2] = uv_th_q[c];
						rdata_d[rvs_pkg::THR_OV_LSB + 2*c +: 2] = ov_th_q[c];
					end
				end
				rvs_pkg::ADDR_STATUS: rdata_d = 32'({valid, live});
				rvs_pkg::ADDR_IRQ: begin
					rdata_d  = 32'(irq_st_q);
					irq_st_d = '0;
				end
				rvs_pkg::ADDR_MASK:   rdata_d = 32'(irq_mask_q);
				rvs_pkg::ADDR_UNLOCK: rdata_d = 32'(unlock_q);
				default: rdata_d = '0;
			endcase
		end
		// a new event wins over the read clear
		irq_st_d = irq_st_d | evt;
		irq_d    = |(irq_st_d & irq_mask_d);
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ctrl_q.secure_en              <= 1'b0;
			ctrl_q.uv_debounce_select     <= rvs_pkg::UV_DEBOUNCE_SELECT_RST;
			ctrl_q.ov_debounce_select     <= rvs_pkg::OV_DEBOUNCE_SELECT_RST;
			ctrl_q.channel_monitor_enable <= rvs_pkg::MON_EN_RST;
			uv_th_q    <= {rvs_pkg::NCH{rvs_pkg::TH_RST}};
			ov_th_q    <= {rvs_pkg::NCH{rvs_pkg::TH_RST}};
			irq_st_q   <= '0;
			irq_mask_q <= '0;
			unlock_q   <= 1'b0;
			rdata      <= '0;
			irq        <= 1'b0;
		end else begin
			ctrl_q     <= ctrl_d;
			uv_th_q    <= uv_th_d;
			ov_th_q    <= ov_th_d;
			irq_st_q   <= irq_st_d;
			irq_mask_q <= irq_mask_d;
			unlock_q   <= unlock_d;
			rdata      <= rdata_d;
			irq        <= irq_d;
		end
	end

	// debounce window lookup
	logic [rvs_pkg::CNT_W-1:0] uv_win, ov_win;

	always_comb begin
		case (ctrl_q.uv_debounce_select)
			2'h0:    uv_win = rvs_pkg::ticks_up(rvs_pkg::UV_DB0_US);
			2'h1:    uv_win = rvs_pkg::ticks_up(rvs_pkg::UV_DB1_US);
			2'h2:    uv_win = rvs_pkg::ticks_up(rvs_pkg::UV_DB2_US);
			default: uv_win = rvs_pkg::ticks_up(rvs_pkg::UV_DB3_US);
		endcase
		case (ctrl_q.ov_debounce_select)
			2'h0:    ov_win = rvs_pkg::ticks_up(rvs_pkg::OV_DB0_US);
			2'h1:    ov_win = rvs_pkg::ticks_up(rvs_pkg::OV_DB1_US);
			2'h2:    ov_win = rvs_pkg::ticks_up(rvs_pkg::OV_DB2_US);
			default: ov_win = rvs_pkg::ticks_up(rvs_pkg::OV_DB3_US);
		endcase
	end

	// threshold and enable outputs toward the comparators
	logic [3:0][7:0] uv_pct_d, ov_pct_d;

	always_comb begin
		for (int c = 0; c < rvs_pkg::NCH; c++) begin
			case (uv_th_q[c])
				2'h0:    uv_pct_d[c] = rvs_pkg::UV_PCT0;
				2'h1:    uv_pct_d[c] = rvs_pkg::UV_PCT1;
				2'h2:    uv_pct_d[c] = rvs_pkg::UV_PCT2;
				default: uv_pct_d[c] = rvs_pkg::UV_PCT3;
			endcase
			case (ov_th_q[c])
				2'h0:    ov_pct_d[c] = rvs_pkg::OV_PCT0;
				2'h1:    ov_pct_d[c] = rvs_pkg::OV_PCT1;
				2'h2:    ov_pct_d[c] = rvs_pkg::OV_PCT2;
				default: ov_pct_d[c] = rvs_pkg::OV_PCT3;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			uv_threshold_pct <= {rvs_pkg::NCH{rvs_pkg::UV_PCT0}};
			ov_threshold_pct <= {rvs_pkg::NCH{rvs_pkg::OV_PCT0}};
			monitor_enable   <= rvs_pkg::MON_EN_RST;
		end else begin
			uv_threshold_pct <= uv_pct_d;
			ov_threshold_pct <= ov_pct_d;
			monitor_enable   <= ctrl_q.channel_monitor_enable;
		end
	end

	// one supervisor per regulator
	genvar g;
	generate
		for (g = 0; g < rvs_pkg::NCH; g++) begin : gen_chan
			logic [1:0] st, ev;

			rvs_channel u_chan (
				.clk            (clk),
				.rst_n          (rst_n_q),
				.tick           (tick_q),
				.monitor_enable (ctrl_q.channel_monitor_enable[g]),
				.reg_on         (reg_on[g]),
				.in_regulation  (in_regulation[g]),
				.cmp            ({ov_cmp[g], uv_cmp[g]}),
				.win            ({ov_win, uv_win}),
				.status         (st),
				.evt            (ev),
				.valid          (valid[g])
			);
			assign undervoltage_status[g] = st[0];
			assign overvoltage_status[g]  = st[1];
			assign live.uv[g]             = st[0];
			assign live.ov[g]             = st[1];
			assign evt.uv[g]              = ev[0];
			assign evt.ov[g]              = ev[1];
		end
	endgenerate

endmodule // rvs_supervisor

/* File: tb/rvs_plant.sv */
`timescale 1ns/1ps
module rvs_plant #(
	parameter int RAMP = 1500
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [3:0] on,
	input  wire logic [3:0] under,
	input  wire logic [3:0] over,
	output logic [3:0]      reg_on,
	output logic [3:0]      in_regulation,
	output logic [3:0]      uv_cmp,
	output logic [3:0]      ov_cmp
);
	logic [3:0][15:0] ramp_q, ramp_d;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			in_regulation[i] = on[i] && ramp_q[i] == 16'(RAMP);
			ramp_d[i] = (!on[i]) ? 16'h0 : ramp_q[i] + {15'h0, !in_regulation[i]};
		end
		reg_on = on;
		// output below threshold while off or ramping
		uv_cmp = ~in_regulation | under;
		ov_cmp = over & in_regulation;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ramp_q <= '0;
		end else begin
			ramp_q <= ramp_d;
		end
	end
endmodule // rvs_plant

/* File: tb/rvs_supervisor_assertions.sv */
`timescale 1ns/1ps
module rvs_supervisor_checker (
	input wire logic            clk,
	input wire logic            resetn,
	input wire logic [7:0]      addr,
	input wire logic [31:0]     wdata,
	input wire logic            wr_en,
	input wire logic            rd_en,
	input wire logic [31:0]     rdata,
	input wire logic [3:0]      reg_on,
	input wire logic [3:0]      in_regulation,
	input wire logic [3:0]      uv_cmp,
	input wire logic [3:0]      ov_cmp,
	input wire logic [3:0]      monitor_enable,
	input wire logic [3:0][7:0] uv_threshold_pct,
	input wire logic [3:0][7:0] ov_threshold_pct,
	input wire logic [3:0]      undervoltage_status,
	input wire logic [3:0]      overvoltage_status,
	input wire logic            irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	logic [11:0] uv_run_q, uv_run_d, ov_run_q, ov_run_d;
	logic        live, thr_wr;
	// run length of an unmasked out-of-range condition on channel 0
	always_comb begin
		live = monitor_enable[0] & reg_on[0] & in_regulation[0];
		thr_wr = wr_en && addr == rvs_pkg::ADDR_THRESH;
		uv_run_d = (live & uv_cmp[0]) ? uv_run_q + {11'h0, ~&uv_run_q} : 12'h000;
		ov_run_d = (live & ov_cmp[0]) ? ov_run_q + {11'h0, ~&ov_run_q} : 12'h000;
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			uv_run_q <= 12'h000;
			ov_run_q <= 12'h000;
		end else begin
			uv_run_q <= uv_run_d;
			ov_run_q <= ov_run_d;
		end
	end
	function automatic logic [7:0] uv_pct(input logic [31:0] w);
		return 8'h5f - {5'h0, w[1:0], 1'b0};
	endfunction
	function automatic logic [7:0] ov_pct(input logic [31:0] w);
		return 8'h69 + {5'h0, w[15:14], 1'b0};
	endfunction
	sequence s_uv_low2;
		!uv_cmp[0] [*2];
	endsequence
	sequence s_ov_low2;
		!ov_cmp[0] [*2];
	endsequence
	property p_rdata_idle;
		!$past(rd_en) |-> rdata == 32'h0;
	endproperty
	property p_uv_thr;
		$past(thr_wr, 3) && !$past(wr_en, 2) && !$past(wr_en) |-> uv_threshold_pct[0] == uv_pct($past(wdata, 3));
	endproperty
	property p_ov_thr;
		$past(thr_wr, 3) && !$past(wr_en, 2) && !$past(wr_en) |-> ov_threshold_pct[3] == ov_pct($past(wdata, 3));
	endproperty
	property p_uv_deadline;
		uv_run_q >= 12'h7d5 |-> undervoltage_status[0];
	endproperty
	property p_ov_deadline;
		ov_run_q >= 12'he15 |-> overvoltage_status[0];
	endproperty
	property p_uv_rise;
		$rose(undervoltage_status[0]) |-> $past(uv_cmp[0]) && $past(uv_cmp[0], 4);
	endproperty
	property p_uv_drop;
		s_uv_low2 |=> !undervoltage_status[0];
	endproperty
	property p_ov_drop;
		s_ov_low2 |=> !overvoltage_status[0];
	endproperty
	property p_off_clear;
		(~monitor_enable & ~$past(monitor_enable) & ~$past(monitor_enable, 2)
			& (undervoltage_status | overvoltage_status)) == 4'h0;
	endproperty
	property p_mask_off;
		(~reg_on & ~$past(reg_on) & ~$past(reg_on, 2) & (undervoltage_status | overvoltage_status)) == 4'h0;
	endproperty
	property p_irq_fall;
		$fell(irq) |-> $past(rd_en) || $past(rd_en, 2) || $past(wr_en) || $past(wr_en, 2);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
	a_uv_thr: assert property (p_uv_thr) else $error("uv threshold percent wrong");
	a_ov_thr: assert property (p_ov_thr) else $error("ov threshold percent wrong");
	a_uv_deadline: assert property (p_uv_deadline) else $error("uv status late");
	a_ov_deadline: assert property (p_ov_deadline) else $error("ov status late");
	a_uv_rise: assert property (p_uv_rise) else $error("uv status without condition");
	a_uv_drop: assert property (p_uv_drop) else $error("uv status held after clear");
	a_ov_drop: assert property (p_ov_drop) else $error("ov status held after clear");
	a_off_clear: assert property (p_off_clear) else $error("status set on disabled channel");
	a_mask_off: assert property (p_mask_off) else $error("status set on regulator off");
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without access");
endmodule // rvs_supervisor_checker
bind rvs_supervisor rvs_supervisor_checker u_chk (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
	.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .reg_on(reg_on), .in_regulation(in_regulation),
	.uv_cmp(uv_cmp), .ov_cmp(ov_cmp), .monitor_enable(monitor_enable), .uv_threshold_pct(uv_threshold_pct),
	.ov_threshold_pct(ov_threshold_pct), .undervoltage_status(undervoltage_status),
	.overvoltage_status(overvoltage_status), .irq(irq));

/* File: tb/rvs_supervisor_tb_top.sv */
`timescale 1ns/1ps
module rvs_supervisor_tb_top;
	logic            clk, resetn, wr_en, rd_en, irq;
	logic [7:0]      addr;
	logic [31:0]     wdata, rdata, got, thr;
	logic [3:0]      on, under, over, reg_on, in_regulation, uv_cmp, ov_cmp, monitor_enable;
	logic [3:0]      undervoltage_status, overvoltage_status;
	logic [3:0][7:0] uv_threshold_pct, ov_threshold_pct;
	int              miscompares, checked, seed, n, t;
	int              uv_us[4] = '{5, 15, 30, 40};
	int              ov_us[4] = '{30, 50, 80, 125};
	rvs_supervisor DUT (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
		.rdata(rdata), .reg_on(reg_on), .in_regulation(in_regulation), .uv_cmp(uv_cmp), .ov_cmp(ov_cmp),
		.monitor_enable(monitor_enable), .uv_threshold_pct(uv_threshold_pct), .ov_threshold_pct(ov_threshold_pct),
		.undervoltage_status(undervoltage_status), .overvoltage_status(overvoltage_status), .irq(irq));
	rvs_plant u_plant (.clk(clk), .rst_n(resetn), .on(on), .under(under), .over(over), .reg_on(reg_on),
		.in_regulation(in_regulation), .uv_cmp(uv_cmp), .ov_cmp(ov_cmp));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	function automatic int db_ticks(input int us);
		return (us + 9) / 10;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 got = rdata;
	endtask
	// count edges until channel 0 flags, bounded
	task automatic wait_st(input logic ov, input int lim);
		n = 0;
		while (((ov ? overvoltage_status[0] : undervoltage_status[0]) !== 1'b1) && n < lim) begin
			@(posedge clk);
			n++;
		end
		if (n >= lim) begin
			miscompares++;
			test_done();
		end
	endtask
	task automatic test_done;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		seed = 45;
		miscompares = 0;
		checked = 0;
		{resetn, wr_en, rd_en, addr, wdata, on, under, over} = '0;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		rd(rvs_pkg::ADDR_CTRL);
		chk(got, 32'h02f);
		for (int c = 0; c < 6; c++) begin
			thr = (c < 4) ? {16'h0, {8{2'(c)}}} : 32'($random(seed)) & 32'h0000ffff;
			wr(rvs_pkg::ADDR_THRESH, thr);
			repeat (3) @(posedge clk);
			for (int i = 0; i < 4; i++) begin
				chk(32'(uv_threshold_pct[i]), 32'h5f - 32'(2 * thr[2*i +: 2]));
				chk(32'(ov_threshold_pct[i]), 32'h69 + 32'(2 * thr[8+2*i +: 2]));
			end
		end
		rd(rvs_pkg::ADDR_THRESH);
		chk(got, thr);
		wr(rvs_pkg::ADDR_CTRL, 32'h11f);
		wr(rvs_pkg::ADDR_CTRL, 32'h110);
		repeat (2) @(posedge clk);
		chk(32'(monitor_enable), 32'hf);
		wr(rvs_pkg::ADDR_UNLOCK, rvs_pkg::UNLOCK_KEY);
		rd(rvs_pkg::ADDR_UNLOCK);
		chk(got, 32'h1);
		wr(rvs_pkg::ADDR_CTRL, 32'h11e);
		repeat (2) @(posedge clk);
		chk(32'(monitor_enable), 32'he);
		wr(rvs_pkg::ADDR_CTRL, 32'h00f);
		wr(rvs_pkg::ADDR_CTRL, 32'h00f);
		on <= 4'hf;
		repeat (1000) @(posedge clk);
		chk(32'(undervoltage_status), 32'h0);
		repeat (700) @(posedge clk);
		for (int c = 0; c < 8; c++) begin
			wr(rvs_pkg::ADDR_CTRL, 32'h00f | 32'(c % 4) << (c < 4 ? 4 : 6));
			t = (c < 4) ? db_ticks(uv_us[c]) : db_ticks(ov_us[c - 4]);
			under <= {3'h0, c < 4};
			over <= {3'h0, c >= 4};
			wait_st(c >= 4, 3000);
			chk(32'(n > t * 200 && n <= t * 200 + 201), 32'h1);
			chk({overvoltage_status, undervoltage_status}, (c < 4) ? 32'h01 : 32'h10);
			under <= 4'h0;
			over <= 4'h0;
			repeat (4) @(posedge clk);
		end
		wr(rvs_pkg::ADDR_CTRL, 32'h02f);
		under <= 4'h1;
		repeat (500) @(posedge clk);
		under <= 4'h0;
		@(posedge clk);
		under <= 4'h1;
		wait_st(1'b0, 1200);
		chk(32'(n > 600), 32'h1);
		under <= 4'h0;
		wr(rvs_pkg::ADDR_MASK, 32'hff);
		rd(rvs_pkg::ADDR_MASK);
		chk(got, 32'hff);
		over <= 4'h1;
		wait_st(1'b1, 3000);
		repeat (3) @(posedge clk);
		chk(32'(irq), 32'h1);
		rd(rvs_pkg::ADDR_IRQ);
		chk(got, 32'h11);
		rd(rvs_pkg::ADDR_IRQ);
		chk(got, 32'h0);
		chk(32'(irq), 32'h0);
		wr(rvs_pkg::ADDR_CTRL, 32'h00e);
		repeat (3) @(posedge clk);
		chk({overvoltage_status, undervoltage_status}, 32'h0);
		over <= 4'h0;
		rd(rvs_pkg::ADDR_STATUS);
		chk(got, 32'he00);
		wr(rvs_pkg::ADDR_CTRL, 32'h00f);
		rd(rvs_pkg::ADDR_STATUS);
		chk(got, 32'he00);
		repeat (605) @(posedge clk);
		rd(rvs_pkg::ADDR_STATUS);
		chk(got, 32'hf00);
		wr(8'h3c, 32'hffffffff);
		rd(8'h3c);
		chk(got, 32'h0);
		test_done();
	end
endmodule // rvs_supervisor_tb_top
